// >>> amx_defs.svh
// register offsets, reset values, field positions and frame counts
`ifndef AMX_DEFS_SVH
`define AMX_DEFS_SVH

`define AMX_ADR_INMUX    7'h06
`define AMX_ADR_WBD      7'h07
`define AMX_ADR_DIR      7'h08
`define AMX_ADR_SCS      7'h09
`define AMX_ADR_AMASK    7'h0A
`define AMX_ADR_DMASK    7'h0B

`define AMX_RST_INMUX    7'h60
`define AMX_RST_WBD      8'h02
`define AMX_RST_DIR      7'h00
`define AMX_RST_SCS      7'h00
`define AMX_RST_AMASK    8'h00
`define AMX_RST_DMASK    7'h20

`define AMX_WM_WBD       8'h8F
`define AMX_WM_AMASK     8'hDF
`define AMX_AN_FLAGS     8'hD7
`define AMX_DG_FLAGS     7'h7B

`define AMX_IM_A1        6
`define AMX_IM_A2        5
`define AMX_IM_B1        4
`define AMX_IM_B2        3
`define AMX_IM_C1        2
`define AMX_IM_C2        1
`define AMX_IM_D12       0
`define AMX_WB_HOLD      7
`define AMX_WB_F1        3
`define AMX_WB_F2        2
`define AMX_AM_PROTOFF   3
`define AMX_DM_CRCOFF    5
`define AMX_DM_CLKFRZ    2

`define AMX_CMD_LAST     5'h07
`define AMX_DATA_LAST    5'h0F
`define AMX_CRC_LAST     5'h17
`define AMX_LEN_RAW      5'h10
`define AMX_LEN_CRC      5'h18
`define AMX_CRC_POLY     8'h07
`define AMX_SLOT_DEV     3'h7

`endif

// >>> amx_pkg.sv
// types shared by the amplifier control register block
package amx_pkg;

	typedef enum logic [1:0] {
		AMX_LK_IDLE = 2'b00,
		AMX_LK_DEV  = 2'b01,
		AMX_LK_PASS = 2'b10
	} amx_link_t;

	typedef struct packed {
		logic chan1_switch_pos;
		logic chan1_switch_neg;
		logic chan2_switch_pos;
		logic chan2_switch_neg;
		logic testmux_switch_pos;
		logic testmux_switch_neg;
		logic input_short_switch;
	} amx_sw_t;

	typedef struct packed {
		logic       gain_override;
		logic       fault_current_switch_pos;
		logic       fault_current_switch_neg;
		logic [1:0] detect_current_sel;
	} amx_wb_t;

	typedef struct packed {
		logic checksum_bad;
		logic address_bad;
		logic edge_count_bad;
	} amx_err_t;

endpackage

// >>> amx_regs.sv
// serial register port with switch, wire-break, select routing and mask registers
//
// What this block does
// - each channel switch bit closes its switch when one, opens when zero
// - both channel pairs never closed together unless exclusion is turned off
// - test mux switch bits tie an amplifier input to the test mux output
// - input short bit ties both amplifier inputs together
// - gain hold bit keeps programmed gain while fault currents are on
// - each fault switch bit independently routes its detect current
// - fault switch on and hold clear forces default gain; readback unchanged
// - two-bit current code sets both detect sources, reset code 10
// - seven direction bits make pins outputs when one, inputs after reset
// - pin is a slave select only when its select and direction bits are one
// - host select pulses walk enabled pins then the device, round robin
// - analog mask bits disable matching analog flags, reset to zero
// - digital mask bits disable matching digital flags
// - checksum off bit resets to one; when clear writes and reads carry a checksum
// - counter freeze bit stops the master clock counter
// - fault summary is the OR of all unmasked flags
`timescale 1ns/100ps
`include "amx_defs.svh"

module amx_regs #(
	parameter int CNT_W = 16
) (
	input  wire logic               clock,
	input  wire logic               nrst,
	input  wire logic               cs_n_pin,
	input  wire logic               sclk_pin,
	input  wire logic               mosi_pin,
	output logic                    miso_o,
	output logic                    miso_oe,
	input  wire logic [6:0]         gpio_drive_val,
	output logic      [6:0]         gpio_o,
	output logic      [6:0]         gpio_oe,
	output amx_pkg::amx_sw_t        sw_o,
	output amx_pkg::amx_wb_t        wb_o,
	input  wire logic [7:0]         analog_flags,
	input  wire logic [6:0]         digital_flags,
	output logic      [7:0]         analog_mask_o,
	output logic      [6:0]         digital_mask_o,
	output logic                    fault_summary,
	output logic      [CNT_W-1:0]   master_clk_counter,
	output amx_pkg::amx_err_t       err_o
);
	import amx_pkg::*;

	// elaboration check on counter width
	generate
		if (CNT_W < 1)
		begin : g_bad
			$error("CNT_W must be at least one");
		end
	endgenerate

	// checksum over command and data byte, msb first
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--)
		begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `AMX_CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// next select slot: next enabled pin above cur (lowest enabled pin when cur is the device), else the device
	function automatic logic [2:0] next_slot(input logic [2:0] cur, input logic [6:0] en);
		logic [2:0] n;
		logic       hit;
		n = `AMX_SLOT_DEV;
		hit = 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			if (!hit && en[i] && (cur == `AMX_SLOT_DEV || i > int'(cur)))
			begin
				n = 3'(i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction

	logic            cs_s1_r, cs_s2_r, cs_d_r;
	logic            sclk_s1_r, sclk_s2_r, sclk_d_r;
	logic            mosi_s1_r, mosi_s2_r;
	amx_link_t       link_r, link_nxt;
	logic [2:0]      slot_r;
	logic [4:0]      cnt_r;
	logic [23:0]     sr_r;
	logic [15:0]     tx_r;
	logic [6:0]      adr_r;
	logic            rd_r;
	logic            adr_ok_r;
	logic            crc_frm_r;
	logic            miso_r, miso_oe_r;
	logic [6:0]      inmux_r;
	logic [7:0]      wbd_r;
	logic [6:0]      dir_r;
	logic [6:0]      scs_r;
	logic [7:0]      amask_r;
	logic [6:0]      dmask_r;
	amx_sw_t         sw_r, sw_nxt;
	amx_wb_t         wb_r, wb_nxt;
	amx_err_t        err_r, err_nxt;
	logic [6:0]      gpio_r, gpio_nxt;
	logic [6:0]      gpio_oe_r;
	logic            fault_r;
	logic [CNT_W-1:0] mclk_r;

	// pin synchronisers, second stage is the first one read
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_s1_r   <= 1'b1;
			cs_s2_r   <= 1'b1;
			cs_d_r    <= 1'b1;
			sclk_s1_r <= 1'b0;
			sclk_s2_r <= 1'b0;
			sclk_d_r  <= 1'b0;
			mosi_s1_r <= 1'b0;
			mosi_s2_r <= 1'b0;
		end
		else
		begin
			cs_s1_r   <= cs_n_pin;
			cs_s2_r   <= cs_s1_r;
			cs_d_r    <= cs_s2_r;
			sclk_s1_r <= sclk_pin;
			sclk_s2_r <= sclk_s1_r;
			sclk_d_r  <= sclk_s2_r;
			mosi_s1_r <= mosi_pin;
			mosi_s2_r <= mosi_s1_r;
		end
	end

	// edge detection and frame decode
	wire        cs_fall   = cs_d_r & ~cs_s2_r;
	wire        cs_rise   = ~cs_d_r & cs_s2_r;
	wire        sclk_rise = sclk_s2_r & ~sclk_d_r;
	wire        sclk_fall = ~sclk_s2_r & sclk_d_r;
	wire        dev_rise  = (link_r == AMX_LK_DEV) & sclk_rise;
	wire        dev_fall  = (link_r == AMX_LK_DEV) & sclk_fall;
	wire [23:0] sr_in     = {sr_r[22:0], mosi_s2_r};
	wire        crc_on    = crc_frm_r; // mode held for the whole frame
	wire [4:0]  frame_len = crc_on ? `AMX_LEN_CRC : `AMX_LEN_RAW;
	wire        cmd_done  = dev_rise & (cnt_r == `AMX_CMD_LAST);
	wire        wr_raw    = dev_rise & ~rd_r & ~crc_on & (cnt_r == `AMX_DATA_LAST);
	wire        crc_end   = dev_rise & ~rd_r & crc_on & (cnt_r == `AMX_CRC_LAST);
	wire        crc_match = (sr_in[7:0] == crc8(sr_in[23:8]));
	wire        wr_go     = (wr_raw | (crc_end & crc_match)) & adr_ok_r;
	wire [7:0]  wdat      = crc_on ? sr_in[15:8] : sr_in[7:0];
	wire [6:0]  cmd_adr   = sr_in[6:0];
	wire [6:0]  scs_en    = scs_r & dir_r;

	// register read mux, unmapped reads as zero
	wire cmd_ok = (cmd_adr >= `AMX_ADR_INMUX) && (cmd_adr <= `AMX_ADR_DMASK);
	wire [7:0] rdat =
		(cmd_adr == `AMX_ADR_INMUX) ? {1'b0, inmux_r} :
		(cmd_adr == `AMX_ADR_WBD)   ? wbd_r :
		(cmd_adr == `AMX_ADR_DIR)   ? {1'b0, dir_r} :
		(cmd_adr == `AMX_ADR_SCS)   ? {1'b0, scs_r} :
		(cmd_adr == `AMX_ADR_AMASK) ? amask_r :
		(cmd_adr == `AMX_ADR_DMASK) ? {1'b0, dmask_r} : 8'h00;
	wire [7:0] rcrc = crc8({sr_in[7:0], rdat});

	// write strobes per register
	wire we_inmux = wr_go & (adr_r == `AMX_ADR_INMUX);
	wire we_wbd   = wr_go & (adr_r == `AMX_ADR_WBD);
	wire we_dir   = wr_go & (adr_r == `AMX_ADR_DIR);
	wire we_scs   = wr_go & (adr_r == `AMX_ADR_SCS);
	wire we_amask = wr_go & (adr_r == `AMX_ADR_AMASK);
	wire we_dmask = wr_go & (adr_r == `AMX_ADR_DMASK);

	// link phase: device frame or pass-through to a select pin
	always_comb
	begin
		link_nxt = link_r;
		unique case (link_r)
			AMX_LK_IDLE:
				if (cs_fall)
					link_nxt = (slot_r == `AMX_SLOT_DEV) ? AMX_LK_DEV : AMX_LK_PASS;
			AMX_LK_DEV,
			AMX_LK_PASS:
				if (cs_rise)
					link_nxt = AMX_LK_IDLE;
			default:
				link_nxt = AMX_LK_IDLE;
		endcase
	end

	// link state and select slot
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			link_r <= AMX_LK_IDLE;
			slot_r <= `AMX_SLOT_DEV;
		end
		else
		begin
			link_r <= link_nxt;
			if (cs_rise && link_r != AMX_LK_IDLE)
				slot_r <= next_slot(slot_r, scs_en);
		end
	end

	// bit counter and receive shifter
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_r <= 5'h00;
			sr_r  <= 24'h000000;
		end
		else if (cs_fall)
			cnt_r <= 5'h00;
		else if (dev_rise)
		begin
			sr_r <= sr_in;
			if (cnt_r != 5'h1F)
				cnt_r <= cnt_r + 5'h01;
		end
	end

	// command capture and read response load
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			adr_r    <= 7'h00;
			rd_r     <= 1'b0;
			adr_ok_r <= 1'b0;
			crc_frm_r <= 1'b0;
			tx_r     <= 16'h0000;
		end
		else if (cs_fall)
		begin
			rd_r      <= 1'b0;
			crc_frm_r <= ~dmask_r[`AMX_DM_CRCOFF];
		end
		else if (cmd_done)
		begin
			adr_r    <= cmd_adr;
			rd_r     <= sr_in[7];
			adr_ok_r <= cmd_ok;
			tx_r     <= {rdat, rcrc};
		end
		else if (dev_fall && rd_r && cnt_r >= 5'h08 && cnt_r < frame_len)
			tx_r <= {tx_r[14:0], 1'b0};
	end

	// read data out on falling clock, checksum byte only when enabled
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			miso_r    <= 1'b0;
			miso_oe_r <= 1'b0;
		end
		else
		begin
			if (cs_rise)
				miso_oe_r <= 1'b0;
			else if (cmd_done)
				miso_oe_r <= sr_in[7];
			if (dev_fall && rd_r && cnt_r >= 5'h08 && cnt_r < frame_len)
				miso_r <= tx_r[15];
		end
	end

	// port error pulses
	always_comb
	begin
		err_nxt = '0;
		err_nxt.checksum_bad   = crc_end & ~crc_match;
		err_nxt.address_bad    = cmd_done & ~cmd_ok;
		err_nxt.edge_count_bad = cs_rise & (link_r == AMX_LK_DEV) & (cnt_r != frame_len);
	end

	// register file
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			inmux_r <= `AMX_RST_INMUX;
			wbd_r   <= `AMX_RST_WBD;
			dir_r   <= `AMX_RST_DIR;
			scs_r   <= `AMX_RST_SCS;
			amask_r <= `AMX_RST_AMASK;
			dmask_r <= `AMX_RST_DMASK;
		end
		else
		begin
			if (we_inmux)
				inmux_r <= wdat[6:0];
			if (we_wbd)
				wbd_r <= wdat & `AMX_WM_WBD;
			if (we_dir)
				dir_r <= wdat[6:0];
			if (we_scs)
				scs_r <= wdat[6:0];
			if (we_amask)
				amask_r <= wdat & `AMX_WM_AMASK;
			if (we_dmask)
				dmask_r <= wdat[6:0];
		end
	end

	// switch matrix with channel exclusion
	wire req_a  = inmux_r[`AMX_IM_A1] | inmux_r[`AMX_IM_A2];
	wire req_b  = inmux_r[`AMX_IM_B1] | inmux_r[`AMX_IM_B2];
	wire on_a   = sw_r.chan1_switch_pos | sw_r.chan1_switch_neg;
	wire on_b   = sw_r.chan2_switch_pos | sw_r.chan2_switch_neg;
	wire clash  = req_a & req_b & ~amask_r[`AMX_AM_PROTOFF];
	wire keep_a = ~clash | ~(on_b & ~on_a);
	wire keep_b = ~clash | (on_b & ~on_a);
	assign sw_nxt = '{
		chan1_switch_pos:   inmux_r[`AMX_IM_A1] & keep_a,
		chan1_switch_neg:   inmux_r[`AMX_IM_A2] & keep_a,
		chan2_switch_pos:   inmux_r[`AMX_IM_B1] & keep_b,
		chan2_switch_neg:   inmux_r[`AMX_IM_B2] & keep_b,
		testmux_switch_pos: inmux_r[`AMX_IM_C1],
		testmux_switch_neg: inmux_r[`AMX_IM_C2],
		input_short_switch: inmux_r[`AMX_IM_D12]
	};

	// wire-break test controls and gain override
	wire fault_any = wbd_r[`AMX_WB_F1] | wbd_r[`AMX_WB_F2];
	assign wb_nxt = '{
		gain_override:            fault_any & ~wbd_r[`AMX_WB_HOLD],
		fault_current_switch_pos: wbd_r[`AMX_WB_F1],
		fault_current_switch_neg: wbd_r[`AMX_WB_F2],
		detect_current_sel:       wbd_r[1:0]
	};

	// pin values: enabled select pins idle high, low while addressed
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_pin
			wire hit = (link_r == AMX_LK_PASS) & (slot_r == 3'(gi));
			assign gpio_nxt[gi] = scs_en[gi] ? ~hit : gpio_drive_val[gi];
		end
	endgenerate

	// fault summary over unmasked flags
	wire [7:0] an_live = analog_flags & ~amask_r & `AMX_AN_FLAGS;
	wire [6:0] dg_live = digital_flags & ~dmask_r & `AMX_DG_FLAGS;
	wire       fault_nxt = (|an_live) | (|dg_live);

	// registered outputs
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sw_r      <= '0;
			wb_r      <= '0;
			err_r     <= '0;
			gpio_r    <= 7'h00;
			gpio_oe_r <= 7'h00;
			fault_r   <= 1'b0;
		end
		else
		begin
			sw_r      <= sw_nxt;
			wb_r      <= wb_nxt;
			err_r     <= err_nxt;
			gpio_r    <= gpio_nxt;
			gpio_oe_r <= dir_r;
			fault_r   <= fault_nxt;
		end
	end

	// master clock counter with freeze
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			mclk_r <= '0;
		else if (!dmask_r[`AMX_DM_CLKFRZ])
			mclk_r <= mclk_r + 1'b1;
	end

	assign miso_o             = miso_r;
	assign miso_oe            = miso_oe_r;
	assign gpio_o             = gpio_r;
	assign gpio_oe            = gpio_oe_r;
	assign sw_o               = sw_r;
	assign wb_o               = wb_r;
	assign err_o              = err_r;
	assign fault_summary      = fault_r;
	assign analog_mask_o      = amask_r;
	assign digital_mask_o     = dmask_r;
	assign master_clk_counter = mclk_r;

endmodule

// >>> amx_regs_properties.sv
// concurrent checks on the amplifier register block ports
`timescale 1ns/100ps
`include "amx_defs.svh"
module amx_regs_properties #(
	parameter int CNT_W = 16
) (
	input logic                 clock,
	input logic                 nrst,
	input logic                 cs_n_pin,
	input logic                 miso_oe,
	input logic [6:0]           gpio_drive_val,
	input logic [6:0]           gpio_o,
	input logic [6:0]           gpio_oe,
	input amx_pkg::amx_sw_t     sw_o,
	input amx_pkg::amx_wb_t     wb_o,
	input logic [7:0]           analog_flags,
	input logic [6:0]           digital_flags,
	input logic [7:0]           analog_mask_o,
	input logic [6:0]           digital_mask_o,
	input logic                 fault_summary,
	input logic [CNT_W-1:0]     master_clk_counter
);
	import amx_pkg::*;
	// pair closure, addressed select pins and live unmasked flags
	wire       pair1 = sw_o.chan1_switch_pos | sw_o.chan1_switch_neg;
	wire       pair2 = sw_o.chan2_switch_pos | sw_o.chan2_switch_neg;
	wire [6:0] low_sel = gpio_oe & ~gpio_o & gpio_drive_val;
	wire       fault_now = |(analog_flags & ~analog_mask_o & `AMX_AN_FLAGS)
		| |(digital_flags & ~digital_mask_o & `AMX_DG_FLAGS);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	a_pair_excl: assert property (
		!analog_mask_o[3] && !$past(analog_mask_o[3]) |-> !(pair1 && pair2)
	) else $error("both channel pairs closed while protected");
	a_count_frozen: assert property (
		digital_mask_o[2] && $past(digital_mask_o[2]) && $past(nrst)
		|-> $stable(master_clk_counter)
	) else $error("counter moved while frozen");
	a_count_runs: assert property (
		!digital_mask_o[2] && !$past(digital_mask_o[2]) && $past(nrst)
		|-> master_clk_counter == CNT_W'($past(master_clk_counter) + 1'b1)
	) else $error("counter did not step");
	a_summary_or: assert property (
		$past(nrst) |-> fault_summary == $past(fault_now)
	) else $error("summary differs from unmasked flags");
	a_override_cause: assert property (
		wb_o.gain_override |-> wb_o.fault_current_switch_pos || wb_o.fault_current_switch_neg
	) else $error("gain forced without a fault switch");
	a_select_in_frame: assert property (
		$rose(|low_sel) && $stable(gpio_oe) |-> $past(!cs_n_pin, 3)
	) else $error("select pin driven low outside a host frame");
	a_select_single: assert property (
		$onehot0(low_sel)
	) else $error("more than one slave selected");
	a_reply_in_frame: assert property (
		$rose(miso_oe) |-> !cs_n_pin
	) else $error("read data driven outside a frame");
endmodule
bind amx_regs amx_regs_properties #(.CNT_W(CNT_W)) u_props (
	.clock(clock), .nrst(nrst), .cs_n_pin(cs_n_pin), .miso_oe(miso_oe),
	.gpio_drive_val(gpio_drive_val), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .sw_o(sw_o),
	.wb_o(wb_o), .analog_flags(analog_flags), .digital_flags(digital_flags),
	.analog_mask_o(analog_mask_o), .digital_mask_o(digital_mask_o),
	.fault_summary(fault_summary), .master_clk_counter(master_clk_counter)
);

// >>> amx_host.sv
// serial host model: mode 0 frames, msb first, optional checksum
`timescale 1ns/100ps
module amx_host (
	output logic cs_n_pin,
	output logic sclk_pin,
	output logic mosi_pin,
	input  logic miso_o,
	input  logic miso_oe
);
	logic [23:0] sh;
	// idle: select high, serial clock low
	initial
	begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		mosi_pin = 1'b0;
		sh = 24'h0;
	end
	// crc-8 poly 0x07, zero start, command byte then data byte
	function automatic logic [7:0] crc8(input logic [15:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// n bits from the top of f; reply bit taken just before each rise
	task automatic xfer(input logic [23:0] f, input int n);
		cs_n_pin = 1'b0;
		#400;
		for (int i = 0; i < n; i++)
		begin
			mosi_pin = f[23-i];
			#250;
			sh = {sh[22:0], miso_o & miso_oe};
			sclk_pin = 1'b1;
			#150;
			sclk_pin = 1'b0;
		end
		#250;
		cs_n_pin = 1'b1;
		mosi_pin = ~mosi_pin; // released line keeps no stale level
		#400;
	endtask
endmodule

// >>> amx_regs_tb.sv
// self-checking bench for the amplifier register block
`timescale 1ns/100ps
module amx_regs_tb;
	import amx_pkg::*;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [6:0]  gpio_drive_val = 7'h7F;
	logic [7:0]  analog_flags = 8'h00;
	logic [6:0]  digital_flags = 7'h00;
	logic        cs_n, sclk, mosi, miso, miso_oe, fault;
	logic [6:0]  gpio_o, gpio_oe, dmask;
	logic [7:0]  amask, bad;
	logic [15:0] cnt, cnt0;
	amx_sw_t     sw;
	amx_wb_t     wb;
	amx_err_t    err;
	logic [2:0]  seen = 3'b000;
	logic        crc_on = 1'b0;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [6:0]  sel [5] = '{7'h0C, 7'h09, 7'h0D, 7'h0C, 7'h09};
	amx_regs #(.CNT_W(16)) dut (
		.clock(clock), .nrst(nrst), .cs_n_pin(cs_n), .sclk_pin(sclk), .mosi_pin(mosi),
		.miso_o(miso), .miso_oe(miso_oe), .gpio_drive_val(gpio_drive_val),
		.gpio_o(gpio_o), .gpio_oe(gpio_oe), .sw_o(sw), .wb_o(wb),
		.analog_flags(analog_flags), .digital_flags(digital_flags),
		.analog_mask_o(amask), .digital_mask_o(dmask), .fault_summary(fault),
		.master_clk_counter(cnt), .err_o(err)
	);
	amx_host host (
		.cs_n_pin(cs_n), .sclk_pin(sclk), .mosi_pin(mosi), .miso_o(miso), .miso_oe(miso_oe)
	);
	always #25 clock = ~clock;
	// sticky record of error pulses, and the hang limit
	always @(posedge clock)
	begin
		seen <= seen | err;
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_mismatch++;
			complete_run;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d, crc_on ? host.crc8({1'b0, a, d}) : 8'h00}, crc_on ? 24 : 16);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		host.xfer({1'b1, a, 16'h0}, crc_on ? 24 : 16);
		if (crc_on)
			chk(host.sh[15:0], {e, host.crc8({1'b1, a, e})});
		else
			chk(host.sh[7:0], e);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		tick(2);
		nrst = 1'b1;
		tick(4);
		chk(sw, 7'h60);
		chk(wb, 5'h02);
		rd(7'h06, 8'h60);
		rd(7'h07, 8'h02);
		rd(7'h08, 8'h00);
		rd(7'h09, 8'h00);
		rd(7'h0A, 8'h00);
		rd(7'h0B, 8'h20);
		$display("test reset done");
		wr(7'h06, 8'h07);
		chk(sw, 7'h07);
		wr(7'h06, 8'h18);
		chk(sw, 7'h18);
		wr(7'h06, 8'h78);
		chk(sw, 7'h18);
		rd(7'h06, 8'h78);
		wr(7'h0A, 8'h08);
		wr(7'h06, 8'h78);
		chk(sw, 7'h78);
		wr(7'h0A, 8'h00);
		$display("test switches done");
		for (int c = 0; c < 4; c++)
		begin
			wr(7'h07, 8'h0C | 8'(c));
			chk(wb, 5'h1C | 5'(c));
		end
		wr(7'h07, 8'hF4);
		chk(wb, 5'h04);
		rd(7'h07, 8'h84);
		wr(7'h07, 8'h02);
		chk(wb, 5'h02);
		$display("test wire break done");
		wr(7'h08, 8'h0D);
		wr(7'h09, 8'h07);
		chk(gpio_oe, 7'h0D);
		for (int k = 0; k < 5; k++)
		begin
			fork
				wr(7'h06, 8'(k));
				begin
					#2000;
					chk(gpio_o & 7'h0D, sel[k]);
				end
			join
		end
		chk(sw, 7'h02);
		wr(7'h09, 8'h00);
		$display("test select done");
		analog_flags = 8'h28;
		tick(3);
		chk(fault, 1'b0);
		analog_flags = 8'hD7;
		wr(7'h0A, 8'hD7);
		chk(fault, 1'b0);
		wr(7'h0A, 8'hD3);
		chk(fault, 1'b1);
		analog_flags = 8'h00;
		digital_flags = 7'h7B;
		wr(7'h0B, 8'h7B);
		chk(fault, 1'b0);
		wr(7'h0B, 8'h3B);
		chk(fault, 1'b1);
		digital_flags = 7'h00;
		wr(7'h0B, 8'h24);
		cnt0 = cnt;
		tick(10);
		chk(cnt, cnt0);
		wr(7'h0B, 8'h20);
		cnt0 = cnt;
		tick(10);
		chk(cnt, cnt0 + 16'd10);
		$display("test masks done");
		wr(7'h0B, 8'h00);
		crc_on = 1'b1;
		rd(7'h0B, 8'h00);
		wr(7'h06, 8'h40);
		chk(sw, 7'h40);
		bad = ~host.crc8({8'h06, 8'h01});
		host.xfer({8'h06, 8'h01, bad}, 24);
		chk({seen[2], sw}, 8'hC0);
		wr(7'h0B, 8'h20);
		crc_on = 1'b0;
		wr(7'h15, 8'hFF);
		host.xfer(24'h0C0000, 12);
		chk(seen[1:0], 2'b11);
		$display("test refusals done");
		complete_run;
	end
endmodule
